// ### src/rbt_defines.svh
/*
  Constants of the registered bus transceiver: data width, pin-control
  bit positions and reset values. Included by the package and modules.
*/
`ifndef RBT_DEFINES_SVH
`define RBT_DEFINES_SVH

// Data word width of each port
`define RBT_W 18
// Number of sampled control pins
`define RBT_NCTRL 8
// Control bit positions in the sampled control vector
`define RBT_FWD_OE 0
`define RBT_REV_OE_N 1
`define RBT_FWD_LE 2
`define RBT_REV_LE 3
`define RBT_FWD_CLK 4
`define RBT_REV_CLK 5
`define RBT_A_DRV 6
`define RBT_B_DRV 7
// Reset value of the control samples: reverse enable off (high)
`define RBT_CTRL_RST 8'h02
// Reset value of data words
`define RBT_DATA_RST 18'h00000
// Buffer depth and reset count
`define RBT_DEPTH 2
`define RBT_CNT_RST 2'h0

`endif

// ### src/rbt_pkg.sv
/*
  Types of the registered bus transceiver: the packed state structs of
  the top module and of the two-entry buffer. Assumes rbt_defines.svh.
*/
`include "rbt_defines.svh"

package rbt_pkg;

  typedef logic [`RBT_W-1:0] rbt_word_t;

  // State of the two-entry buffer
  typedef struct packed {
    rbt_word_t [`RBT_DEPTH-1:0] mem;
    logic                       wr;
    logic                       rd;
    logic [1:0]                 cnt;
  } rbt_skid_s;

  // State of the transceiver top
  typedef struct packed {
    rbt_word_t              a_s1;
    rbt_word_t              a_s2;
    rbt_word_t              b_s1;
    rbt_word_t              b_s2;
    logic [`RBT_NCTRL-1:0]  c_s1;
    logic [`RBT_NCTRL-1:0]  c_s2;
    logic [`RBT_NCTRL-1:0]  c_s3;
    rbt_word_t              a_hold;
    rbt_word_t              b_hold;
    rbt_word_t              fwd_store;
    rbt_word_t              rev_store;
    logic                   fwd_new;
    logic                   rev_new;
    rbt_word_t              b_out;
    logic                   b_oe;
    rbt_word_t              a_out;
    logic                   a_oe;
  } rbt_top_s;

endpackage

// ### src/rbt_skid.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a synchronous reset copy from the top and one clock.
*/
`timescale 1ns/1ns
`include "rbt_defines.svh"

module rbt_skid
  import rbt_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  // Filling side
  input  wire logic      in_valid_i,
  output logic           in_ready_o,
  input  wire rbt_word_t in_data_i,
  // Draining side
  output logic           out_valid_o,
  input  wire logic      out_ready_i,
  output rbt_word_t      out_data_o
);

  rbt_skid_s s_q;   // Registered state
  rbt_skid_s s_d;   // Next state
  logic      push;  // Word taken in
  logic      pop;   // Word handed out

  // Full and empty come from the count
  assign in_ready_o  = (s_q.cnt != 2'h2);
  assign out_valid_o = (s_q.cnt != 2'h0);
  assign out_data_o  = s_q.mem[s_q.rd];

  // Next state: write on push, advance read on pop
  always_comb begin
    s_d  = s_q;
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    if (push) begin
      s_d.mem[s_d.wr] = in_data_i;
      s_d.wr          = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    // Count moves only when one side acts alone
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 2'h1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 2'h1;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{mem: '0, wr: 1'b0, rd: 1'b0, cnt: `RBT_CNT_RST};
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ### src/rbt_top.sv
/*
  Registered 18-bit bus transceiver between an A port and a B port,
  modelled on a system clock. Each direction has a combined latch and
  capture register, a two-entry buffer and a registered output stage.
  Assumes all pins come from outside the clock domain; sink ready inputs
  come from logic on clk_i. The wire level is resolved outside from the
  output enables.
*/
`timescale 1ns/1ns
`include "rbt_defines.svh"

module rbt_top
  import rbt_pkg::*;
#(
  parameter bit BUS_HOLD = 1'b1  // Bus-hold variant present
)
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      resetn_i,
  // Port A pin
  input  wire rbt_word_t a_i,
  output rbt_word_t      a_o,
  output logic           a_oe_o,
  input  wire logic      a_ext_drive_i,
  // Port B pin
  input  wire rbt_word_t b_i,
  output rbt_word_t      b_o,
  output logic           b_oe_o,
  input  wire logic      b_ext_drive_i,
  // Control pins
  input  wire logic      fwd_output_enable_i,
  input  wire logic      rev_output_enable_n_i,
  input  wire logic      fwd_latch_enable_i,
  input  wire logic      rev_latch_enable_i,
  input  wire logic      fwd_capture_clock_i,
  input  wire logic      rev_capture_clock_i,
  // Receivers ready to take a new output word
  input  wire logic      fwd_sink_ready_i,
  input  wire logic      rev_sink_ready_i
);

  logic      rst_s1_q;   // Reset release, first stage
  logic      rst_n_q;    // Reset release used by the design
  rbt_top_s  s_q;        // Registered state
  rbt_top_s  s_d;        // Next state
  logic      fwd_rdy;    // Forward buffer can take a word
  logic      rev_rdy;    // Reverse buffer can take a word
  logic      fwd_ov;     // Forward buffer holds a word
  logic      rev_ov;     // Reverse buffer holds a word
  rbt_word_t fwd_od;     // Forward buffer head
  rbt_word_t rev_od;     // Reverse buffer head
  logic      fwd_rise;   // Forward capture clock rising edge
  logic      rev_rise;   // Reverse capture clock rising edge

  // Combined latch and capture register step
  function automatic rbt_word_t rbt_step(input logic le, input logic rise,
                                         input rbt_word_t d, input rbt_word_t cur);
    rbt_step = (le || rise) ? d : cur;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Edges are seen between the second and third control stages
  assign fwd_rise = s_q.c_s2[`RBT_FWD_CLK] && !s_q.c_s3[`RBT_FWD_CLK];
  assign rev_rise = s_q.c_s2[`RBT_REV_CLK] && !s_q.c_s3[`RBT_REV_CLK];

  // Next state of synchronisers, storage and output stages
  always_comb begin
    s_d = s_q;
    // Pin synchronisers
    s_d.a_s1 = a_i;
    s_d.a_s2 = s_q.a_s1;
    s_d.b_s1 = b_i;
    s_d.b_s2 = s_q.b_s1;
    s_d.c_s1 = {b_ext_drive_i, a_ext_drive_i, rev_capture_clock_i, fwd_capture_clock_i,
                rev_latch_enable_i, fwd_latch_enable_i, rev_output_enable_n_i, fwd_output_enable_i};
    s_d.c_s2 = s_q.c_s1;
    s_d.c_s3 = s_q.c_s2;
    // Input level keeper: follows only while driven in the hold variant
    if (!BUS_HOLD || s_q.c_s2[`RBT_A_DRV]) begin
      s_d.a_hold = s_q.a_s2;
    end
    if (!BUS_HOLD || s_q.c_s2[`RBT_B_DRV]) begin
      s_d.b_hold = s_q.b_s2;
    end
    // Forward storage; held while the buffer is full
    if (fwd_rdy) begin
      s_d.fwd_store = rbt_step(s_q.c_s2[`RBT_FWD_LE], fwd_rise, s_q.a_hold, s_q.fwd_store);
      s_d.fwd_new   = (s_d.fwd_store != s_q.fwd_store);
    end
    // Reverse storage, its own register
    if (rev_rdy) begin
      s_d.rev_store = rbt_step(s_q.c_s2[`RBT_REV_LE], rev_rise, s_q.b_hold, s_q.rev_store);
      s_d.rev_new   = (s_d.rev_store != s_q.rev_store);
    end
    // Output stages take the buffer head when the receiver is ready
    if (fwd_ov && fwd_sink_ready_i) begin
      s_d.b_out = fwd_od;
    end
    if (rev_ov && rev_sink_ready_i) begin
      s_d.a_out = rev_od;
    end
    // Output enables touch only their own port drivers
    s_d.b_oe = s_q.c_s2[`RBT_FWD_OE];
    s_d.a_oe = !s_q.c_s2[`RBT_REV_OE_N];
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '{a_s1: `RBT_DATA_RST, a_s2: `RBT_DATA_RST, b_s1: `RBT_DATA_RST,
               b_s2: `RBT_DATA_RST, c_s1: `RBT_CTRL_RST, c_s2: `RBT_CTRL_RST,
               c_s3: `RBT_CTRL_RST, a_hold: `RBT_DATA_RST, b_hold: `RBT_DATA_RST,
               fwd_store: `RBT_DATA_RST, rev_store: `RBT_DATA_RST, fwd_new: 1'b0,
               rev_new: 1'b0, b_out: `RBT_DATA_RST, b_oe: 1'b0,
               a_out: `RBT_DATA_RST, a_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Forward buffer between storage and B output stage
  rbt_skid u_fwd_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_q),
    .in_valid_i  (s_q.fwd_new),
    .in_ready_o  (fwd_rdy),
    .in_data_i   (s_q.fwd_store),
    .out_valid_o (fwd_ov),
    .out_ready_i (fwd_sink_ready_i),
    .out_data_o  (fwd_od)
  );

  // Reverse buffer between storage and A output stage
  rbt_skid u_rev_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_q),
    .in_valid_i  (s_q.rev_new),
    .in_ready_o  (rev_rdy),
    .in_data_i   (s_q.rev_store),
    .out_valid_o (rev_ov),
    .out_ready_i (rev_sink_ready_i),
    .out_data_o  (rev_od)
  );

  // Pin outputs straight from flip-flops
  assign a_o    = s_q.a_out;
  assign a_oe_o = s_q.a_oe;
  assign b_o    = s_q.b_out;
  assign b_oe_o = s_q.b_oe;

  // B drivers follow the synchronised forward enable one cycle later
  b_enable_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    $rose(s_q.c_s2[`RBT_FWD_OE]) |=> b_oe_o)
    else $error("B enable did not follow forward enable");

  // A drivers on when the reverse enable is low
  a_enable_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    ##1 (a_oe_o == !$past(s_q.c_s2[`RBT_REV_OE_N])))
    else $error("A enable polarity wrong");

  // Transparent forward path copies held A data
  fwd_transp_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (s_q.c_s2[`RBT_FWD_LE] && fwd_rdy) |=> (s_q.fwd_store == $past(s_q.a_hold)))
    else $error("Forward store not transparent");

  // Forward storage holds without enable or edge
  fwd_hold_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (!s_q.c_s2[`RBT_FWD_LE] && !fwd_rise) |=> $stable(s_q.fwd_store))
    else $error("Forward store changed while latched");

  // Forward capture on a rising clock edge
  fwd_capture_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (!s_q.c_s2[`RBT_FWD_LE] && s_q.c_s2[`RBT_FWD_CLK] && !s_q.c_s3[`RBT_FWD_CLK] && fwd_rdy)
    |=> (s_q.fwd_store == $past(s_q.a_hold)))
    else $error("Forward capture missed");

  // Reverse transparent path copies held B data
  rev_transp_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (s_q.c_s2[`RBT_REV_LE] && rev_rdy) |=> (s_q.rev_store == $past(s_q.b_hold)))
    else $error("Reverse store not transparent");

  // Reverse storage untouched by forward activity
  rev_indep_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (!s_q.c_s2[`RBT_REV_LE] && !rev_rise) |=> $stable(s_q.rev_store))
    else $error("Reverse store disturbed");

  // Released A input keeps its level
  a_keep_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (BUS_HOLD && !s_q.c_s2[`RBT_A_DRV]) |=> $stable(s_q.a_hold))
    else $error("A input level not kept");

  // B output word appears only from a buffer pop
  b_data_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    !(fwd_ov && fwd_sink_ready_i) |=> $stable(b_o))
    else $error("B output changed without a pop");

endmodule

// ### test/rbt_bus_model.sv
/*
  Far-side bus party of one transceiver port: drives its word,
  releases the wire, and gates the receiver's ready.
  Assumes the bench sets drive, word and stall after clk_i edges.
*/
`timescale 1ns/1ns

module rbt_bus_model
  import rbt_pkg::*;
(
  // Clock
  input  wire logic      clk_i,
  // Bench controls
  input  wire logic      drive_i,
  input  wire rbt_word_t word_i,
  input  wire logic      stall_i,
  // Device pin side
  input  wire logic      dev_oe_i,
  input  wire rbt_word_t dev_word_i,
  output rbt_word_t      pin_o,
  output logic           ext_drive_o,
  output logic           sink_ready_o
);
  rbt_word_t last_q = 18'h00000;  // Last level seen driven on the wire

  // Wire level: device first, then the party, else inverse of last level
  assign pin_o        = dev_oe_i ? dev_word_i : (drive_i ? word_i : ~last_q);
  assign ext_drive_o  = drive_i & ~dev_oe_i;
  assign sink_ready_o = ~stall_i;

  // Remember the driven level so a released wire never repeats it
  always @(posedge clk_i) begin
    if (dev_oe_i || drive_i) begin
      last_q <= pin_o;
    end
  end
endmodule

// ### test/tb.sv
/*
  Self-checking bench of the transceiver top: table of mode cases
  both ways, then clock-high hold, bus hold, receiver stall and reset.
  Assumes the bus models resolve the pins from the output enables.
*/
`timescale 1ns/1ns

module tb;
  import rbt_pkg::*;

  // One table case: direction, mode, data and expected output
  typedef struct packed {
    logic      rev;
    logic      le;
    logic      pulse;
    rbt_word_t data;
    rbt_word_t exp_w;
  } rbt_row_s;

  logic      clk_i = 1'b0, resetn_i = 1'b0;
  logic      fwd_oe = 1'b0, rev_oe_n = 1'b1, fwd_le = 1'b0, rev_le = 1'b0;
  logic      fwd_clk = 1'b0, rev_clk = 1'b0;
  logic      a_drive = 1'b1, b_drive = 1'b1, a_stall = 1'b0, b_stall = 1'b0;
  rbt_word_t a_word = 18'h00000, b_word = 18'h00000;
  rbt_word_t a_pin, b_pin, a_o, b_o;
  logic      a_oe, b_oe, a_ext, b_ext, fwd_rdy, rev_rdy;
  int        fails = 0, n_compared = 0, cycles = 0;
  rbt_row_s  rows [7] = '{
    '{1'b0, 1'b1, 1'b0, 18'h3ffff, 18'h3ffff}, '{1'b0, 1'b1, 1'b0, 18'h15555, 18'h15555},
    '{1'b0, 1'b0, 1'b1, 18'h2aaaa, 18'h2aaaa}, '{1'b0, 1'b0, 1'b0, 18'h00001, 18'h2aaaa},
    '{1'b1, 1'b1, 1'b0, 18'h0abcd, 18'h0abcd}, '{1'b1, 1'b0, 1'b1, 18'h30f0f, 18'h30f0f},
    '{1'b1, 1'b0, 1'b0, 18'h00002, 18'h30f0f}};

  always #5 clk_i = ~clk_i;

  rbt_top i_rbt_top (.clk_i(clk_i), .resetn_i(resetn_i), .a_i(a_pin), .a_o(a_o), .a_oe_o(a_oe),
    .a_ext_drive_i(a_ext), .b_i(b_pin), .b_o(b_o), .b_oe_o(b_oe), .b_ext_drive_i(b_ext),
    .fwd_output_enable_i(fwd_oe), .rev_output_enable_n_i(rev_oe_n), .fwd_latch_enable_i(fwd_le),
    .rev_latch_enable_i(rev_le), .fwd_capture_clock_i(fwd_clk), .rev_capture_clock_i(rev_clk),
    .fwd_sink_ready_i(fwd_rdy), .rev_sink_ready_i(rev_rdy));
  rbt_bus_model i_rbt_bus_model_a (.clk_i(clk_i), .drive_i(a_drive), .word_i(a_word), .stall_i(a_stall),
    .dev_oe_i(a_oe), .dev_word_i(a_o), .pin_o(a_pin), .ext_drive_o(a_ext), .sink_ready_o(rev_rdy));
  rbt_bus_model i_rbt_bus_model_b (.clk_i(clk_i), .drive_i(b_drive), .word_i(b_word), .stall_i(b_stall),
    .dev_oe_i(b_oe), .dev_word_i(b_o), .pin_o(b_pin), .ext_drive_o(b_ext), .sink_ready_o(fwd_rdy));

  // Verdict and end of run
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compare one value, count it, report a mismatch
  task automatic cmp(input rbt_word_t got, input rbt_word_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait whole clock cycles
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Point traffic one way: that direction's enable on, the other off, the sourcing party drives
  task automatic set_dir(input logic rev);
    @(posedge clk_i);
    fwd_oe   <= ~rev;
    rev_oe_n <= ~rev;
    a_drive  <= ~rev;
    b_drive  <= rev;
  endtask

  // Capture clock high then low, each long enough to be sampled
  task automatic pulse(input logic rev);
    @(posedge clk_i);
    if (rev) rev_clk <= 1'b1; else fwd_clk <= 1'b1;
    wait_n(4);
    if (rev) rev_clk <= 1'b0; else fwd_clk <= 1'b0;
    wait_n(4);
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    // Reset held low, outputs quiet meanwhile
    wait_n(16);
    cmp(a_o, 18'h00000);
    cmp(b_o, 18'h00000);
    cmp({16'h0000, a_oe, b_oe}, 18'h00000);
    resetn_i <= 1'b1;
    wait_n(4);
    // Mode table, both ways
    foreach (rows[i]) begin
      set_dir(rows[i].rev);
      if (rows[i].rev) begin
        rev_le <= rows[i].le;
        b_word <= rows[i].data;
      end else begin
        fwd_le <= rows[i].le;
        a_word <= rows[i].data;
      end
      wait_n(12);
      if (rows[i].pulse) pulse(rows[i].rev);
      wait_n(12);
      cmp(rows[i].rev ? a_o : b_o, rows[i].exp_w);
      cmp({16'h0000, a_oe, b_oe}, rows[i].rev ? 18'h00002 : 18'h00001);
    end
    // Forward store untouched by reverse traffic
    set_dir(1'b0);
    wait_n(12);
    cmp(b_o, 18'h2aaaa);
    // Clock raised before the enable drops, then data changes
    fwd_le <= 1'b1;
    a_word <= 18'h0f0f0;
    wait_n(12);
    fwd_clk <= 1'b1;
    wait_n(4);
    fwd_le <= 1'b0;
    wait_n(4);
    a_word <= 18'h00ff0;
    wait_n(12);
    cmp(b_o, 18'h0f0f0);
    fwd_clk <= 1'b0;
    // Released A input keeps its last driven level
    fwd_le <= 1'b1;
    a_word <= 18'h12345;
    wait_n(12);
    a_drive <= 1'b0;
    wait_n(12);
    cmp(b_o, 18'h12345);
    a_drive <= 1'b1;
    // Receiver stalls while A changes twice, then drains
    b_stall <= 1'b1;
    a_word  <= 18'h11111;
    wait_n(12);
    a_word <= 18'h22222;
    wait_n(12);
    cmp(b_o, 18'h12345);
    b_stall <= 1'b0;
    wait_n(12);
    cmp(b_o, 18'h22222);
    // Mid-run reset clears the outputs; the path refills after release
    resetn_i <= 1'b0;
    wait_n(4);
    cmp(a_o, 18'h00000);
    cmp(b_o, 18'h00000);
    cmp({16'h0000, a_oe, b_oe}, 18'h00000);
    resetn_i <= 1'b1;
    wait_n(16);
    cmp(b_o, 18'h22222);
    cmp({16'h0000, a_oe, b_oe}, 18'h00001);
    complete_run();
  end
endmodule
